//--- core_pkg.sv
// Shared constants and types of the CPU context and memory map block
package core_pkg;

  // Address space and on-chip regions
  localparam int ADDR_W = 18;
  localparam logic [17:0] ROM_BYTES = 18'h08000;
  localparam logic [17:0] ROM_SEG1_BASE = 18'h10000;
  localparam logic [17:0] RAM_BASE = 18'h0FA00;
  localparam logic [17:0] RAM_BYTES = 18'h00400;
  localparam logic [17:0] CRA_BASE = 18'h0FE00;
  localparam logic [17:0] CRA_BYTES = 18'h00200;
  localparam int RAM_WORDS = 512;
  localparam int RAM_AW = 9;

  // Stack and bank reset values
  localparam logic [15:0] STACK_BYTES = 16'h0200;
  localparam logic [15:0] SP_RESET = 16'hFE00;
  localparam logic [15:0] LOWER_RESET = 16'hFE00;
  localparam logic [15:0] UPPER_RESET = 16'hFC00;
  localparam logic [15:0] BANK_RESET = 16'hFA00;

  // Machine cycle timing
  localparam int MACHINE_CYCLE_NS = 100;
  localparam int CLK_MHZ = 250;
  localparam int MC_CLKS = MACHINE_CYCLE_NS * CLK_MHZ / 1000;
  localparam int CYC_SINGLE = 1;
  localparam int CYC_BRANCH = 2;
  localparam int CYC_JC_HIT = 1;
  localparam int CYC_MUL = 5;
  localparam int CYC_DIV = 10;
  localparam logic [7:0] LAT_SINGLE = 8'(CYC_SINGLE * MC_CLKS - 1);
  localparam logic [7:0] LAT_BRANCH = 8'(CYC_BRANCH * MC_CLKS - 1);
  localparam logic [7:0] LAT_JC_HIT = 8'(CYC_JC_HIT * MC_CLKS - 1);
  localparam logic [7:0] LAT_MUL = 8'(CYC_MUL * MC_CLKS - 2);
  localparam logic [7:0] LAT_DIV = 8'(CYC_DIV * MC_CLKS - 2);

  typedef enum logic [3:0] {
    OP_ALU, OP_MUL, OP_DIV, OP_BRANCH, OP_LOAD, OP_STORE, OP_PUSH,
    OP_POP, OP_REG_RD, OP_REG_WR, OP_SET_BANK, OP_SET_SP,
    OP_SET_UPPER, OP_SET_LOWER
  } op_t;

  typedef enum logic [3:0] {
    FN_ADD, FN_SUB, FN_AND, FN_OR, FN_XOR, FN_SHL, FN_SHR, FN_ASHR,
    FN_ROL, FN_ROR, FN_MASK
  } fn_t;

  typedef enum logic [1:0] {AM_DIRECT, AM_INDIRECT, AM_IMMEDIATE} mode_t;

  typedef enum logic [1:0] {RG_RAM, RG_ROM, RG_CRA, RG_EXT} region_t;

endpackage : core_pkg

//--- core_ram.sv
// On-chip RAM, word wide with byte lanes and registered read
`timescale 1ns/1ns
`default_nettype none
module core_ram (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Port
  input wire logic [8:0] addr,
  input wire logic rd_en,
  input wire logic [1:0] wr_be,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);

  logic [15:0] mem [core_pkg::RAM_WORDS];
  logic [15:0] rdata_r;

  // Contents are not cleared; software owns initialisation
  always_ff @(posedge clock) begin
    if (wr_be[0]) begin
      mem[addr][7:0] <= wdata[7:0];
    end
    if (wr_be[1]) begin
      mem[addr][15:8] <= wdata[15:8];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 16'h0000;
    end else if (rd_en) begin
      rdata_r <= mem[addr];
    end
  end

  assign rdata = rdata_r;

endmodule : core_ram
`default_nettype wire

//--- core_muldiv.sv
// Separate multiply and divide unit with fixed latency
`timescale 1ns/1ns
`default_nettype none
module core_muldiv (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Start
  input wire logic start,
  input wire logic is_div,
  input wire logic [31:0] a,
  input wire logic [15:0] b,
  // Result
  output logic done,
  output logic [31:0] result
);

  typedef struct packed {
    logic busy;
    logic [7:0] cnt;
    logic done;
    logic [31:0] res;
  } md_state_t;

  md_state_t s;
  md_state_t n;

  always_comb begin
    n = s;
    n.done = 1'b0;
    if (start) begin
      n.busy = 1'b1;
      if (is_div) begin
        n.cnt = core_pkg::LAT_DIV; // R08
        // Zero divisor gives all-ones quotient and the low 16 bits of the dividend as remainder
        if (b == 16'h0000) begin
          n.res = {a[15:0], 16'hFFFF};
        end else begin
          n.res = {16'(a % {16'h0000, b}), 16'(a / {16'h0000, b})};
        end
      end else begin
        n.cnt = core_pkg::LAT_MUL; // R08
        n.res = a[15:0] * b;
      end
    end else if (s.busy) begin
      if (s.cnt == 8'h00) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end else begin
        n.cnt = s.cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign done = s.done;
  assign result = s.res;

endmodule : core_muldiv
`default_nettype wire

//--- core_context.sv
// CPU context, stack checking, memory map and instruction timing
// Operation
// R01 - One 256 KB space, byte or word access
// R02 - ROM maps into segment 0 or 1
// R03 - 1 KB RAM holds data, stack, banks
// R04 - Sixteen word registers, eight split into bytes
// R05 - 512-byte control register area reserved
// R06 - Most operations take one machine cycle
// R07 - Any shift or rotate in one cycle
// R08 - Branch 2, multiply 5, divide 10
// R09 - Jump cache makes repeated jumps one cycle
// R10 - Bank pointer locates bank anywhere in RAM
// R11 - Stack up to 512 bytes in RAM
// R12 - Every stack access checked against limits
// R13 - 2 or 4 byte instructions, three modes
// R14 - Four-stage pipeline, 16-bit ALU, mask generator; the code takes one request at a time, with no pipeline
// R15 - Stack fault raises trap and status flag
`timescale 1ns/1ns
`default_nettype none
module core_context (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Configuration
  input wire logic rom_seg1,
  input wire logic flag_clear,
  // Request
  input wire logic req_valid,
  input wire core_pkg::op_t req_op,
  input wire core_pkg::fn_t req_fn,
  input wire core_pkg::mode_t req_mode,
  input wire logic req_byte,
  input wire logic req_long,
  input wire logic req_taken,
  input wire logic [3:0] req_reg,
  input wire logic [17:0] req_addr,
  input wire logic [31:0] req_a,
  input wire logic [15:0] req_b,
  // Answer
  output logic busy_r,
  output logic done_r,
  output logic [31:0] result_r,
  output logic [17:0] pc_r,
  // Context
  output logic [15:0] bank_base_pointer_r,
  output logic [15:0] stack_top_reg_r,
  output logic [15:0] stack_upper_limit_r,
  output logic [15:0] stack_lower_limit_r,
  // Stack check
  output logic stack_trap_r,
  output logic overflow_flag_r,
  output logic underflow_flag_r,
  // Outside memory and control register area
  output logic bus_req_r,
  output core_pkg::region_t bus_region_r,
  output logic [17:0] bus_addr_r,
  output logic bus_we_r,
  output logic bus_byte_r,
  output logic [15:0] bus_wdata_r,
  input wire logic bus_ack,
  input wire logic [15:0] bus_rdata
);

  typedef enum logic [1:0] {ST_IDLE, ST_COUNT, ST_MULDIV, ST_BUS} st_t;

  typedef struct packed {
    st_t st;
    logic [7:0] cnt;
    logic busy;
    logic done;
    logic [31:0] res;
    logic [17:0] pc;
    logic [15:0] bank;
    logic [15:0] sp;
    logic [15:0] upper;
    logic [15:0] lower;
    logic jc_v;
    logic [17:0] jc_src;
    logic [17:0] jc_tgt;
    logic rd_pend;
    logic rd_byte;
    logic rd_hi;
    logic bus_rd;
    logic trap;
    logic ovf;
    logic unf;
    logic bus_req;
    core_pkg::region_t bus_region;
    logic [17:0] bus_addr;
    logic bus_we;
    logic bus_byte;
    logic [15:0] bus_wdata;
  } ctx_state_t;

  ctx_state_t s;
  ctx_state_t n;

  logic [8:0] ram_addr;
  logic ram_rd;
  logic [1:0] ram_be;
  logic [15:0] ram_wdata;
  logic [15:0] ram_rdata;
  logic md_start;
  logic md_done;
  logic [31:0] md_res;
  logic [17:0] addr_eff;
  logic [15:0] reg_addr;
  logic [15:0] sp_dn;
  logic [15:0] sp_up;
  logic [15:0] rd_word;
  core_pkg::region_t rg;

  // Region of an address; the ROM window follows the segment strap
  function automatic core_pkg::region_t region_of(logic [17:0] a, logic seg1);
    logic [17:0] rom_base;
    rom_base = seg1 ? core_pkg::ROM_SEG1_BASE : 18'h00000;
    if (a >= rom_base && a < rom_base + core_pkg::ROM_BYTES) begin // R02
      region_of = core_pkg::RG_ROM;
    end else if (a >= core_pkg::CRA_BASE && a < core_pkg::CRA_BASE + core_pkg::CRA_BYTES) begin
      region_of = core_pkg::RG_CRA; // R05
    end else if (a >= core_pkg::RAM_BASE && a < core_pkg::RAM_BASE + core_pkg::RAM_BYTES) begin
      region_of = core_pkg::RG_RAM; // R03
    end else begin
      region_of = core_pkg::RG_EXT; // R01
    end
  endfunction : region_of

  // Word index into RAM; out-of-RAM bank or stack addresses wrap into it
  function automatic logic [8:0] ram_index(logic [17:0] a);
    logic [17:0] d;
    d = a - core_pkg::RAM_BASE;
    ram_index = d[9:1];
  endfunction : ram_index

  function automatic logic [1:0] lanes(logic byte_acc, logic a0);
    lanes = byte_acc ? (a0 ? 2'b10 : 2'b01) : 2'b11; // R01
  endfunction : lanes

  // ALU, barrel shifter and bit-mask generator, all single pass
  function automatic logic [15:0] alu(core_pkg::fn_t f, logic [15:0] a, logic [15:0] b);
    logic [3:0] sh;
    logic [31:0] dbl;
    sh = b[3:0];
    dbl = 32'h0000_0000;
    alu = a;
    case (f)
      core_pkg::FN_ADD: alu = a + b;
      core_pkg::FN_SUB: alu = a - b;
      core_pkg::FN_AND: alu = a & b;
      core_pkg::FN_OR: alu = a | b;
      core_pkg::FN_XOR: alu = a ^ b;
      core_pkg::FN_SHL: alu = a << sh; // R07
      core_pkg::FN_SHR: alu = a >> sh; // R07
      core_pkg::FN_ASHR: alu = $signed(a) >>> sh; // R07
      core_pkg::FN_ROL: begin
        dbl = {a, a} << sh; // R07
        alu = dbl[31:16];
      end
      core_pkg::FN_ROR: begin
        dbl = {a, a} >> sh; // R07
        alu = dbl[15:0];
      end
      core_pkg::FN_MASK: alu = (16'hFFFF << b[3:0]) & (16'hFFFF >> (4'hF - b[7:4])); // R14
      default: alu = a;
    endcase
  endfunction : alu

  core_ram u_ram (
    .clock(clock),
    .reset_n(reset_n),
    .addr(ram_addr),
    .rd_en(ram_rd),
    .wr_be(ram_be),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  core_muldiv u_muldiv (
    .clock(clock),
    .reset_n(reset_n),
    .start(md_start),
    .is_div(req_op == core_pkg::OP_DIV),
    .a(req_a),
    .b(req_b),
    .done(md_done),
    .result(md_res)
  );

  // Sequencer: decode, address and access on accept, then count, multiply/divide or bus wait, then write-back
  always_comb begin
    n = s;
    n.done = 1'b0;
    n.trap = 1'b0;
    n.bus_req = 1'b0;
    ram_addr = 9'h000;
    ram_rd = 1'b0;
    ram_be = 2'b00;
    ram_wdata = req_byte ? {req_b[7:0], req_b[7:0]} : req_b;
    md_start = 1'b0;
    addr_eff = (req_mode == core_pkg::AM_INDIRECT) ? {2'b00, s.res[15:0]} : req_addr; // R13
    rg = region_of(addr_eff, rom_seg1);
    reg_addr = s.bank + {11'h000, req_byte ? {1'b0, req_reg[2:0]} : req_reg, 1'b0} // R04
             + {15'h0000, req_byte & req_reg[3]};
    sp_dn = s.sp - 16'h0002;
    sp_up = s.sp + 16'h0002;
    rd_word = s.rd_hi ? {8'h00, ram_rdata[15:8]} : s.rd_byte ? {8'h00, ram_rdata[7:0]} : ram_rdata;
    // Clear first so that a fault in the same cycle still sets the flag
    if (flag_clear) begin
      n.ovf = 1'b0;
      n.unf = 1'b0;
    end
    unique case (s.st)
      ST_IDLE: begin
        if (req_valid) begin
          n.busy = 1'b1;
          n.st = ST_COUNT;
          n.cnt = core_pkg::LAT_SINGLE; // R06
          n.pc = s.pc + (req_long ? 18'h00004 : 18'h00002); // R13
          n.rd_byte = req_byte;
          n.rd_hi = 1'b0;
          unique case (req_op)
            core_pkg::OP_ALU: n.res = {16'h0000, alu(req_fn, req_a[15:0], req_b)}; // R14
            core_pkg::OP_MUL, core_pkg::OP_DIV: begin
              md_start = 1'b1; // R08
              n.st = ST_MULDIV;
            end
            core_pkg::OP_BRANCH: begin
              if (req_taken) begin
                n.pc = req_addr;
                n.jc_v = 1'b1;
                n.jc_src = s.pc;
                n.jc_tgt = req_addr;
                if (s.jc_v && s.jc_src == s.pc && s.jc_tgt == req_addr) begin
                  n.cnt = core_pkg::LAT_JC_HIT; // R09
                end else begin
                  n.cnt = core_pkg::LAT_BRANCH; // R08
                end
              end
            end
            core_pkg::OP_LOAD, core_pkg::OP_STORE: begin
              if (req_mode == core_pkg::AM_IMMEDIATE) begin
                n.res = req_a; // R13
              end else if (rg == core_pkg::RG_RAM) begin
                ram_addr = ram_index(addr_eff);
                if (req_op == core_pkg::OP_LOAD) begin
                  ram_rd = 1'b1;
                  n.rd_pend = 1'b1;
                  n.rd_hi = req_byte & addr_eff[0];
                end else begin
                  ram_be = lanes(req_byte, addr_eff[0]); // R01
                end
              end else if (!(rg == core_pkg::RG_ROM && req_op == core_pkg::OP_STORE)) begin
                // Writes into ROM are dropped; all else goes outside
                n.st = ST_BUS;
                n.bus_req = 1'b1;
                n.bus_rd = (req_op == core_pkg::OP_LOAD);
                n.bus_region = rg;
                n.bus_addr = addr_eff;
                n.bus_we = (req_op == core_pkg::OP_STORE);
                n.bus_byte = req_byte;
                n.bus_wdata = ram_wdata;
              end
            end
            core_pkg::OP_REG_RD, core_pkg::OP_REG_WR: begin
              ram_addr = ram_index({2'b00, reg_addr}); // R10
              if (req_op == core_pkg::OP_REG_RD) begin
                ram_rd = 1'b1;
                n.rd_pend = 1'b1;
                n.rd_hi = req_byte & req_reg[3]; // R04
              end else begin
                ram_be = lanes(req_byte, reg_addr[0]); // R04
              end
            end
            core_pkg::OP_PUSH: begin
              n.sp = sp_dn;
              ram_addr = ram_index({2'b00, sp_dn}); // R11
              ram_be = 2'b11;
              ram_wdata = req_b;
              if (sp_dn < s.upper) begin // R12
                n.ovf = 1'b1; // R15
                n.trap = 1'b1; // R15
              end
            end
            core_pkg::OP_POP: begin
              n.sp = sp_up;
              ram_addr = ram_index({2'b00, s.sp}); // R11
              ram_rd = 1'b1;
              n.rd_pend = 1'b1;
              n.rd_byte = 1'b0;
              if (sp_up > s.lower) begin // R12
                n.unf = 1'b1; // R15
                n.trap = 1'b1; // R15
              end
            end
            core_pkg::OP_SET_BANK: n.bank = {req_a[15:1], 1'b0}; // R10
            core_pkg::OP_SET_SP: n.sp = {req_a[15:1], 1'b0};
            core_pkg::OP_SET_UPPER: n.upper = {req_a[15:1], 1'b0};
            core_pkg::OP_SET_LOWER: n.lower = {req_a[15:1], 1'b0};
            default: n.st = ST_COUNT;
          endcase
        end
      end
      ST_COUNT: begin
        if (s.cnt == 8'h00) begin // R06
          n.st = ST_IDLE;
          n.busy = 1'b0;
          n.done = 1'b1;
          n.rd_pend = 1'b0;
          if (s.rd_pend) begin
            n.res = {16'h0000, rd_word};
          end
        end else begin
          n.cnt = s.cnt - 8'h01;
        end
      end
      ST_MULDIV: begin
        if (md_done) begin // R08
          n.st = ST_IDLE;
          n.busy = 1'b0;
          n.done = 1'b1;
          n.res = md_res;
        end
      end
      ST_BUS: begin
        // Outside timing belongs to the bus controller, so no fixed latency
        if (bus_ack) begin
          n.st = ST_IDLE;
          n.busy = 1'b0;
          n.done = 1'b1;
          if (s.bus_rd) begin
            n.res = {16'h0000, s.bus_byte ? {8'h00, bus_rdata[7:0]} : bus_rdata};
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.bank <= core_pkg::BANK_RESET;
      s.sp <= core_pkg::SP_RESET;
      s.upper <= core_pkg::UPPER_RESET;
      s.lower <= core_pkg::LOWER_RESET;
      s.bus_region <= core_pkg::RG_RAM;
    end else begin
      s <= n;
    end
  end

  assign busy_r = s.busy;
  assign done_r = s.done;
  assign result_r = s.res;
  assign pc_r = s.pc;
  assign bank_base_pointer_r = s.bank;
  assign stack_top_reg_r = s.sp;
  assign stack_upper_limit_r = s.upper;
  assign stack_lower_limit_r = s.lower;
  assign stack_trap_r = s.trap;
  assign overflow_flag_r = s.ovf;
  assign underflow_flag_r = s.unf;
  assign bus_req_r = s.bus_req;
  assign bus_region_r = s.bus_region;
  assign bus_addr_r = s.bus_addr;
  assign bus_we_r = s.bus_we;
  assign bus_byte_r = s.bus_byte;
  assign bus_wdata_r = s.bus_wdata;

endmodule : core_context
`default_nettype wire

//--- core_context_chk.sv
// Timing, stack and address map checks on the context block
`timescale 1ns/1ns
`default_nettype none
module core_context_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Watched ports
  input wire logic rom_seg1,
  input wire logic req_valid,
  input wire core_pkg::op_t req_op,
  input wire logic req_long,
  input wire logic req_taken,
  input wire logic [17:0] req_addr,
  input wire logic busy_r,
  input wire logic done_r,
  input wire logic [17:0] pc_r,
  input wire logic [15:0] stack_top_reg_r,
  input wire logic [15:0] stack_upper_limit_r,
  input wire logic [15:0] stack_lower_limit_r,
  input wire logic stack_trap_r,
  input wire logic overflow_flag_r,
  input wire logic underflow_flag_r,
  input wire logic bus_req_r,
  input wire core_pkg::region_t bus_region_r,
  input wire logic [17:0] bus_addr_r
);
  logic take;
  assign take = req_valid && !busy_r;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  a_alu_lat: assert property (
    take && req_op == core_pkg::OP_ALU |-> ##25 !done_r ##1 done_r) else $error("alu late");
  a_mul_lat: assert property (
    take && req_op == core_pkg::OP_MUL |-> ##125 !done_r ##1 done_r) else $error("mul late");
  a_div_lat: assert property (
    take && req_op == core_pkg::OP_DIV |-> ##250 !done_r ##1 done_r) else $error("div late");
  a_branch_pc: assert property (
    take && req_op == core_pkg::OP_BRANCH && req_taken |=> pc_r == $past(req_addr))
    else $error("branch target lost");
  a_pc_step: assert property (
    take && req_op == core_pkg::OP_ALU
    |=> pc_r == $past(pc_r) + ($past(req_long) ? 18'h00004 : 18'h00002))
    else $error("pc step wrong");
  a_push_chk: assert property (
    take && req_op == core_pkg::OP_PUSH |=> stack_top_reg_r == $past(stack_top_reg_r) - 16'h0002
    && stack_trap_r == (stack_top_reg_r < $past(stack_upper_limit_r))
    && (overflow_flag_r || !stack_trap_r)) else $error("push check wrong");
  a_pop_chk: assert property (
    take && req_op == core_pkg::OP_POP |=> stack_top_reg_r == $past(stack_top_reg_r) + 16'h0002
    && stack_trap_r == (stack_top_reg_r > $past(stack_lower_limit_r))
    && (underflow_flag_r || !stack_trap_r)) else $error("pop check wrong");
  a_rom_map: assert property (
    bus_req_r && bus_region_r == core_pkg::RG_ROM |-> bus_addr_r[17:15] == {1'b0, rom_seg1, 1'b0})
    else $error("rom outside its segment");
  a_cra_map: assert property (
    bus_req_r && bus_addr_r[17:9] == 9'h07F |-> bus_region_r == core_pkg::RG_CRA)
    else $error("control area misrouted");
endmodule : core_context_chk
bind core_context core_context_chk i_chk (
  .clock, .reset_n, .rom_seg1, .req_valid, .req_op, .req_long, .req_taken, .req_addr, .busy_r,
  .done_r, .pc_r, .stack_top_reg_r, .stack_upper_limit_r, .stack_lower_limit_r, .stack_trap_r,
  .overflow_flag_r, .underflow_flag_r, .bus_req_r, .bus_region_r, .bus_addr_r
);
`default_nettype wire

//--- core_bus_model.sv
// Far-side memory answering outside accesses, fast or slow
`timescale 1ns/1ns
`default_nettype none
module core_bus_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Access
  input wire logic slow,
  input wire logic bus_req_r,
  input wire logic [17:0] bus_addr_r,
  output logic bus_ack,
  output logic [15:0] bus_rdata
);
  int wait_n;
  // Idle data toggles so a stale word never passes as an answer
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wait_n <= 0;
      bus_ack <= 1'b0;
      bus_rdata <= 16'h0000;
    end else begin
      wait_n <= bus_req_r ? (slow ? 6 : 1) : (wait_n > 0 ? wait_n - 1 : 0);
      bus_ack <= !bus_req_r && wait_n == 1;
      bus_rdata <= (!bus_req_r && wait_n == 1) ? bus_addr_r[15:0] ^ 16'h5A5A : ~bus_rdata;
    end
  end
endmodule : core_bus_model
`default_nettype wire

//--- tb.sv
// Self-checking bench for the context block
`timescale 1ns/1ns
`default_nettype none
module tb;
  typedef struct {core_pkg::fn_t fn; logic [15:0] b; logic [15:0] ex;} row_t;
  localparam int MC = core_pkg::MC_CLKS;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic rom_seg1 = 1'b0;
  logic flag_clear = 1'b0;
  logic slow = 1'b0;
  logic req_valid = 1'b0;
  logic req_byte = 1'b0;
  logic req_long = 1'b0;
  logic req_taken = 1'b0;
  core_pkg::op_t req_op = core_pkg::OP_ALU;
  core_pkg::fn_t req_fn = core_pkg::FN_ADD;
  core_pkg::mode_t req_mode = core_pkg::AM_DIRECT;
  logic [3:0] req_reg = 4'h0;
  logic [17:0] req_addr = 18'h00000;
  logic [31:0] req_a = 32'h00000000;
  logic [15:0] req_b = 16'h0000;
  logic busy_r, done_r, stack_trap_r, overflow_flag_r, underflow_flag_r;
  logic bus_req_r, bus_we_r, bus_byte_r, bus_ack;
  logic [31:0] result_r, res;
  logic [17:0] pc_r, bus_addr_r, p;
  logic [15:0] bank_base_pointer_r, stack_top_reg_r, stack_upper_limit_r;
  logic [15:0] stack_lower_limit_r, bus_wdata_r, bus_rdata;
  core_pkg::region_t bus_region_r;
  int failures = 0;
  int check_count = 0;
  int n;
  row_t rows[11];
  core_context i_dut (
    .clock, .reset_n, .rom_seg1, .flag_clear, .req_valid, .req_op, .req_fn, .req_mode,
    .req_byte, .req_long, .req_taken, .req_reg, .req_addr, .req_a, .req_b, .busy_r, .done_r,
    .result_r, .pc_r, .bank_base_pointer_r, .stack_top_reg_r, .stack_upper_limit_r,
    .stack_lower_limit_r, .stack_trap_r, .overflow_flag_r, .underflow_flag_r, .bus_req_r,
    .bus_region_r, .bus_addr_r, .bus_we_r, .bus_byte_r, .bus_wdata_r, .bus_ack, .bus_rdata
  );
  core_bus_model i_far (.clock, .reset_n, .slow, .bus_req_r, .bus_addr_r, .bus_ack, .bus_rdata);
  initial begin
    forever #2 clock = ~clock;
  end
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  // Enter at a rising edge, leave at the edge that sees done
  task automatic run(core_pkg::op_t op, logic [31:0] a, logic [15:0] b, int lat);
    req_op <= op;
    req_a <= a;
    req_b <= b;
    req_valid <= 1'b1;
    @(posedge clock);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (done_r !== 1'b1 && n < 400);
    res = result_r;
    if (n >= 400) begin
      failures++;
      end_of_test();
    end
    if (lat >= 0) chk(n, lat + 1);
  endtask : run
  initial begin
    rows = '{'{core_pkg::FN_ADD, 16'h1234, 16'h9655}, '{core_pkg::FN_SUB, 16'h1234, 16'h71ED},
      '{core_pkg::FN_AND, 16'h1234, 16'h0020}, '{core_pkg::FN_OR, 16'h1234, 16'h9635},
      '{core_pkg::FN_XOR, 16'h1234, 16'h9615}, '{core_pkg::FN_SHL, 16'hFFF4, 16'h4210},
      '{core_pkg::FN_SHR, 16'h000F, 16'h0001}, '{core_pkg::FN_ASHR, 16'h0004, 16'hF842},
      '{core_pkg::FN_ROL, 16'h0004, 16'h4218}, '{core_pkg::FN_ROR, 16'h0001, 16'hC210},
      '{core_pkg::FN_MASK, 16'h0084, 16'h01F0}};
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    chk({bank_base_pointer_r, stack_top_reg_r}, {core_pkg::BANK_RESET, core_pkg::SP_RESET});
    foreach (rows[i]) begin
      req_fn <= rows[i].fn;
      run(core_pkg::OP_ALU, 32'h00008421, rows[i].b, MC);
      chk(res[15:0], rows[i].ex);
    end
    p = pc_r;
    req_long <= 1'b1;
    run(core_pkg::OP_ALU, '0, '0, MC);
    chk(pc_r, p + 18'h00004);
    req_long <= 1'b0;
    run(core_pkg::OP_MUL, 32'h0000FFFF, 16'hFFFF, 5 * MC);
    chk(res, 32'hFFFE0001);
    run(core_pkg::OP_DIV, 32'h00010007, 16'h0003, 10 * MC);
    chk(res, 32'h00025557);
    run(core_pkg::OP_DIV, 32'h00001234, 16'h0000, 10 * MC);
    chk(res, 32'h1234FFFF);
    // Self loop: miss, miss, then cached
    req_taken <= 1'b1;
    req_addr <= 18'h00100;
    run(core_pkg::OP_BRANCH, '0, '0, 2 * MC);
    run(core_pkg::OP_BRANCH, '0, '0, 2 * MC);
    run(core_pkg::OP_BRANCH, '0, '0, MC);
    req_taken <= 1'b0;
    run(core_pkg::OP_BRANCH, '0, '0, MC);
    chk(pc_r, 18'h00102);
    req_reg <= 4'h5;
    run(core_pkg::OP_SET_BANK, 32'h0000FA40, '0, MC);
    run(core_pkg::OP_REG_WR, 32'h0000BEEF, 16'hBEEF, MC);
    req_byte <= 1'b1;
    req_reg <= 4'hD;
    run(core_pkg::OP_REG_RD, '0, '0, MC);
    chk(res[15:0], 16'h00BE);
    req_reg <= 4'hC;
    run(core_pkg::OP_SET_BANK, 32'h0000FA42, '0, MC);
    run(core_pkg::OP_REG_WR, 32'h00000012, 16'h0012, MC);
    req_byte <= 1'b0;
    req_reg <= 4'h4;
    run(core_pkg::OP_REG_RD, '0, '0, MC);
    chk(res[15:0], 16'h12EF);
    req_addr <= 18'h0FA80;
    run(core_pkg::OP_STORE, '0, 16'hCAFE, MC);
    req_byte <= 1'b1;
    run(core_pkg::OP_STORE, '0, 16'h0011, MC);
    req_addr <= 18'h0FA81;
    run(core_pkg::OP_LOAD, '0, '0, MC);
    chk(res[15:0], 16'h00CA);
    req_byte <= 1'b0;
    req_mode <= core_pkg::AM_IMMEDIATE;
    run(core_pkg::OP_LOAD, 32'h0000FA80, '0, MC);
    req_mode <= core_pkg::AM_INDIRECT;
    run(core_pkg::OP_LOAD, '0, '0, MC);
    chk(res[15:0], 16'hCA11);
    req_mode <= core_pkg::AM_DIRECT;
    run(core_pkg::OP_PUSH, '0, 16'h1111, MC);
    run(core_pkg::OP_SET_UPPER, 32'h0000FDFE, '0, MC);
    run(core_pkg::OP_PUSH, '0, 16'h2222, MC);
    chk({stack_top_reg_r, overflow_flag_r}, {16'hFDFC, 1'b1});
    run(core_pkg::OP_POP, '0, '0, MC);
    chk(res[15:0], 16'h2222);
    run(core_pkg::OP_POP, '0, '0, MC);
    chk({res[15:0], underflow_flag_r}, {16'h1111, 1'b0});
    run(core_pkg::OP_POP, '0, '0, MC);
    chk(underflow_flag_r, 1'b1);
    flag_clear <= 1'b1;
    @(posedge clock);
    flag_clear <= 1'b0;
    @(posedge clock);
    chk({overflow_flag_r, underflow_flag_r}, 2'h0);
    slow <= 1'b1;
    rom_seg1 <= 1'b1;
    req_addr <= 18'h10010;
    run(core_pkg::OP_LOAD, '0, '0, -1);
    chk({bus_region_r, res[15:0]}, {core_pkg::RG_ROM, 16'h5A4A});
    rom_seg1 <= 1'b0;
    run(core_pkg::OP_LOAD, '0, '0, -1);
    chk(bus_region_r, core_pkg::RG_EXT);
    req_addr <= 18'h0FE10;
    run(core_pkg::OP_LOAD, '0, '0, -1);
    chk({bus_region_r, res[15:0]}, {core_pkg::RG_CRA, 16'hA44A});
    slow <= 1'b0;
    req_byte <= 1'b1;
    run(core_pkg::OP_STORE, '0, 16'h0034, -1);
    chk({bus_addr_r, bus_we_r, bus_byte_r}, {18'h0FE10, 2'b11});
    chk(bus_wdata_r, 16'h3434);
    req_byte <= 1'b0;
    req_fn <= core_pkg::FN_ADD;
    // Reset in mid-run must put the whole context back
    reset_n <= 1'b0;
    @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    chk(bank_base_pointer_r, core_pkg::BANK_RESET);
    chk(stack_upper_limit_r, core_pkg::UPPER_RESET);
    chk(stack_top_reg_r, core_pkg::SP_RESET);
    chk(stack_lower_limit_r, core_pkg::LOWER_RESET);
    chk(pc_r, 18'h00000);
    run(core_pkg::OP_ALU, 32'h00000001, 16'h0002, MC);
    chk(res[15:0], 16'h0003);
    chk(pc_r, 18'h00002);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
